// file: design/sbs_access_port.sv
// Access logic of a flow-through synchronous burst SRAM with common data I/O,
// including its memory array and a minimal scan bypass path.
// Assumes all pins except out_enable_n are synchronous to ref_clk, and that
// the bus owner resolves the shared data wires from the enables.
//
// Behaviour
// - Register all synchronous inputs on rising clock
// - Read data appears in the capturing cycle
// - Burst order follows sampled order select
// - Two-bit counter generates later burst addresses
// - Byte write enable writes only selected lanes
// - Global write writes all four lanes
// - Both strobes: processor strobe wins
// - Selected strobe starts read; controller needs no write
// - Start latches address into register and counter
// - Processor start ignores write inputs first cycle
// - Write follows processor start next edge
// - Controller strobe with write inputs writes immediately
// - Write cycle tristates data and parity pins
// - Chip selects bank; output enable unclocked
// - Scan samples on rise, shifts out on fall
// - Low select linear, high interleaved
// - Linear adds one; interleaved XORs sequence
// - Advance steps counter in selected order
// - No strobe, advance high: repeat address
`timescale 1ns/1ps
`include "sbs_map.svh"

module sbs_access_port
  import sbs_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   nrst,
  input  wire logic [`SBS_ADDR_W-1:0] addr,
  input  wire logic                   primary_chip_select_n,
  input  wire logic                   expansion_select_high,
  input  wire logic                   expansion_select_low,
  input  wire logic                   cpu_addr_strobe_n,
  input  wire logic                   ctrl_addr_strobe_n,
  input  wire logic                   burst_advance_n,
  input  wire logic                   byte_wr_enable_n,
  input  wire logic [`SBS_LANES-1:0]  byte_lane_select_n,
  input  wire logic                   global_wr_n,
  input  wire logic                   out_enable_n,
  input  wire logic                   burst_mode,
  input  wire logic [`SBS_DATA_W-1:0] dq_sample,
  output logic      [`SBS_DATA_W-1:0] dq_drive,
  output logic      [`SBS_DATA_W-1:0] dq_oe,
  input  wire logic [`SBS_LANES-1:0]  shared_parity_sample,
  output logic      [`SBS_LANES-1:0]  shared_parity_drive,
  output logic      [`SBS_LANES-1:0]  shared_parity_oe,
  input  wire logic                   scan_clk,
  input  wire logic                   scan_data,
  input  wire logic                   scan_mode_sel,
  output logic                        scan_out
);

  localparam int LO_W = `SBS_LO_W;
  localparam int UP_W = `SBS_ADDR_W - `SBS_LO_W;

  // Lanes to write this edge; global write overrides the byte inputs
  function automatic logic [`SBS_LANES-1:0] lane_mask(
    input logic                  gw_n,
    input logic                  bwe_n,
    input logic [`SBS_LANES-1:0] lanes_n
  );
    logic [`SBS_LANES-1:0] m;
    m = `SBS_NO_LANES;
    if (!gw_n) begin
      m = `SBS_ALL_LANES;
    end else if (!bwe_n) begin
      m = ~lanes_n;
    end
    return m;
  endfunction : lane_mask

  sbs_pins_type          pins;
  logic                  selected;
  logic                  cpu_hit;
  logic                  ctrl_hit;
  logic                  start;
  logic                  desel;
  logic                  cont;
  logic [`SBS_LANES-1:0] wmask;
  logic                  wr_req;
  logic [LO_W-1:0]       lo_now;
  logic [`SBS_ADDR_W-1:0] acc_addr;
  sbs_cycle_type         cyc_d;
  logic                  active_q;
  logic [UP_W-1:0]       upper_q;
  logic                  drive_q;
  logic [`SBS_LANE_W-1:0] rd_q [`SBS_LANES];
  logic                  scan_clk_q;
  logic                  bypass_q;
  logic                  scan_out_q;

  // Every edge samples the pins directly; no extra pipeline stage is added
  assign pins = '{ce1_n:   primary_chip_select_n,
                  ce2:     expansion_select_high,
                  ce3_n:   expansion_select_low,
                  cpu_n:   cpu_addr_strobe_n,
                  ctrl_n:  ctrl_addr_strobe_n,
                  adv_n:   burst_advance_n,
                  bwe_n:   byte_wr_enable_n,
                  lanes_n: byte_lane_select_n,
                  gw_n:    global_wr_n};

  assign selected = ~pins.ce1_n & pins.ce2 & ~pins.ce3_n;

  // Processor strobe counts only while the primary select is low
  assign cpu_hit  = ~pins.cpu_n & ~pins.ce1_n;
  assign ctrl_hit = ~pins.ctrl_n & ~cpu_hit;
  assign start    = (cpu_hit | ctrl_hit) & selected;
  assign desel    = (cpu_hit | ctrl_hit) & ~selected;
  assign cont     = ~cpu_hit & pins.ctrl_n & active_q;

  assign wmask  = lane_mask(pins.gw_n, pins.bwe_n, pins.lanes_n);
  assign wr_req = |wmask;

  always_comb begin
    if (desel) begin
      cyc_d = SBS_CYC_DESEL;
    end else if (start && cpu_hit) begin
      cyc_d = SBS_CYC_READ;
    end else if (start) begin
      cyc_d = wr_req ? SBS_CYC_WRITE : SBS_CYC_READ;
    end else if (cont) begin
      cyc_d = wr_req ? SBS_CYC_WRITE : SBS_CYC_READ;
    end else begin
      cyc_d = SBS_CYC_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      active_q <= 1'h0;
    end else if (start) begin
      active_q <= 1'h1;
    end else if (desel) begin
      active_q <= 1'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      upper_q <= `SBS_UPPER_RST;
    end else if (start) begin
      upper_q <= addr[`SBS_ADDR_W-1:LO_W];
    end
  end

  sbs_burst_counter u_counter (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .load       (start),
    .load_lo    (addr[LO_W-1:0]),
    .advance    (cont & ~pins.adv_n),
    .burst_mode (burst_mode),
    .lo_now     (lo_now)
  );

  // Upper bits stay frozen for the burst; only the low pair moves
  assign acc_addr = start ? addr : {upper_q, lo_now};

  // One array per lane keeps each lane single-driver
  genvar gi;
  generate
    for (gi = 0; gi < `SBS_LANES; gi++) begin : g_lane
      logic [`SBS_LANE_W-1:0] lane_mem [`SBS_WORDS];

      always_ff @(posedge ref_clk) begin
        if (cyc_d == SBS_CYC_WRITE && wmask[gi]) begin
          lane_mem[acc_addr] <= {shared_parity_sample[gi],
                                 dq_sample[gi*`SBS_BYTE_W +: `SBS_BYTE_W]};
        end
      end

      // Flow-through: the word is in the flop right after the capturing edge
      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          rd_q[gi] <= `SBS_LANE_RST;
        end else if (cyc_d == SBS_CYC_READ) begin
          rd_q[gi] <= lane_mem[acc_addr];
        end
      end

      assign dq_drive[gi*`SBS_BYTE_W +: `SBS_BYTE_W] = rd_q[gi][`SBS_BYTE_W-1:0];
      assign shared_parity_drive[gi]                 = rd_q[gi][`SBS_PAR_BIT];
    end
  endgenerate

  // Drivers only on read cycles; writes and deselects release the pins
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      drive_q <= 1'h0;
    end else begin
      drive_q <= (cyc_d == SBS_CYC_READ);
    end
  end

  // Output enable is unclocked so the bus owner can turn the wires quickly
  assign dq_oe            = {`SBS_DATA_W{drive_q & ~out_enable_n}};
  assign shared_parity_oe = {`SBS_LANES{drive_q & ~out_enable_n}};

  // Scan clock is slow, so it is edge-detected rather than used as a clock
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      scan_clk_q <= 1'h0;
    end else begin
      scan_clk_q <= scan_clk;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      bypass_q <= 1'h0;
    end else if (scan_clk && !scan_clk_q && !scan_mode_sel) begin
      bypass_q <= scan_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      scan_out_q <= 1'h0;
    end else if (!scan_clk && scan_clk_q) begin
      scan_out_q <= bypass_q;
    end
  end

  assign scan_out = scan_out_q;

endmodule : sbs_access_port

// file: common/sbs_map.svh
// Constants of the synchronous burst SRAM access port: widths, lane layout,
// reset values and burst order codes.
// Assumes inclusion by bare name from the package and the design files.
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH

`define SBS_ADDR_W      18
`define SBS_WORDS       262144
`define SBS_LANES       4
`define SBS_LANE_W      9
`define SBS_BYTE_W      8
`define SBS_DATA_W      32
`define SBS_LO_W        2
`define SBS_PAR_BIT     8
`define SBS_MODE_LINEAR 1'h0
`define SBS_MODE_INTLV  1'h1
`define SBS_SEQ_FIRST   2'h0
`define SBS_SEQ_STEP    2'h1
`define SBS_LO_RST      2'h0
`define SBS_UPPER_RST   16'h0000
`define SBS_LANE_RST    9'h000
`define SBS_ALL_LANES   4'hF
`define SBS_NO_LANES    4'h0

`endif

// file: common/sbs_pkg.sv
// Types shared by the burst SRAM access port and its burst counter.
// Assumes sbs_map.svh on the include path.
`include "sbs_map.svh"

package sbs_pkg;

  // Sampled control pins of one clock edge
  typedef struct packed {
    logic                 ce1_n;
    logic                 ce2;
    logic                 ce3_n;
    logic                 cpu_n;
    logic                 ctrl_n;
    logic                 adv_n;
    logic                 bwe_n;
    logic [`SBS_LANES-1:0] lanes_n;
    logic                 gw_n;
  } sbs_pins_type;

  typedef enum logic [1:0] {
    SBS_CYC_IDLE  = 2'b00,
    SBS_CYC_READ  = 2'b01,
    SBS_CYC_WRITE = 2'b10,
    SBS_CYC_DESEL = 2'b11
  } sbs_cycle_type;

endpackage : sbs_pkg

// file: design/sbs_burst_counter.sv
// Two-bit wraparound burst counter feeding the low address bits.
// Assumes load and advance are already qualified by the access logic.
`timescale 1ns/1ps
`include "sbs_map.svh"

module sbs_burst_counter
  import sbs_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  input  wire logic                 load,
  input  wire logic [`SBS_LO_W-1:0] load_lo,
  input  wire logic                 advance,
  input  wire logic                 burst_mode,
  output logic      [`SBS_LO_W-1:0] lo_now
);

  logic [`SBS_LO_W-1:0] first_q;
  logic [`SBS_LO_W-1:0] seq_q;
  logic [`SBS_LO_W-1:0] first_d;
  logic [`SBS_LO_W-1:0] seq_d;

  // Step count wraps modulo four, never carries upward
  always_comb begin
    first_d = load ? load_lo : first_q;
    if (load) begin
      seq_d = `SBS_SEQ_FIRST;
    end else if (advance) begin
      seq_d = seq_q + `SBS_SEQ_STEP;
    end else begin
      seq_d = seq_q;
    end
  end

  // Order chosen each edge from the sampled strap
  always_comb begin
    if (burst_mode == `SBS_MODE_INTLV) begin
      lo_now = first_d ^ seq_d;
    end else begin
      lo_now = first_d + seq_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      first_q <= `SBS_LO_RST;
      seq_q   <= `SBS_SEQ_FIRST;
    end else begin
      first_q <= first_d;
      seq_q   <= seq_d;
    end
  end

endmodule : sbs_burst_counter

// file: verification/sbs_access_port_asserts.sv
// Checker of the access port, bound to its top module.
// Assumes scan_clk levels are held for at least two ref_clk cycles.
`timescale 1ns/1ps
`include "sbs_map.svh"

module sbs_access_port_asserts
  import sbs_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        primary_chip_select_n,
  input wire logic        expansion_select_high,
  input wire logic        expansion_select_low,
  input wire logic        cpu_addr_strobe_n,
  input wire logic        ctrl_addr_strobe_n,
  input wire logic        byte_wr_enable_n,
  input wire logic [3:0]  byte_lane_select_n,
  input wire logic        global_wr_n,
  input wire logic        out_enable_n,
  input wire logic [31:0] dq_drive,
  input wire logic [31:0] dq_oe,
  input wire logic [3:0]  shared_parity_oe,
  input wire logic        scan_clk,
  input wire logic        scan_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic sel, cpu_hit, ctrl_hit, wr;
  assign sel = !primary_chip_select_n && expansion_select_high && !expansion_select_low;
  assign cpu_hit = !cpu_addr_strobe_n && !primary_chip_select_n;
  assign ctrl_hit = !ctrl_addr_strobe_n && !cpu_hit;
  assign wr = !global_wr_n || (!byte_wr_enable_n && byte_lane_select_n != `SBS_ALL_LANES);
  sequence cpu_start; cpu_hit && sel; endsequence
  sequence late_write; cpu_addr_strobe_n && ctrl_addr_strobe_n && wr; endsequence
  sequence ctrl_write; ctrl_hit && sel && wr; endsequence
  sequence ctrl_read; ctrl_hit && sel && !wr; endsequence
  chk_ctrl_read_drive: assert property (ctrl_read ##1 !out_enable_n |-> dq_oe == '1)
    else $error("read data not driven after controller start");
  chk_oe_async_off: assert property (out_enable_n |-> dq_oe == '0)
    else $error("drivers on while output enable high");
  chk_cpu_read_drive: assert property (cpu_start ##1 !out_enable_n |-> dq_oe == '1)
    else $error("read data not driven after processor start");
  chk_ctrl_wr_float: assert property (ctrl_write |=> dq_oe == '0 && shared_parity_oe == '0)
    else $error("pins driven in controller write");
  chk_late_wr_float: assert property (cpu_start ##1 late_write |=> dq_oe == '0)
    else $error("pins driven in write after processor start");
  chk_desel_float: assert property ((cpu_hit || !ctrl_addr_strobe_n) && !sel |=> dq_oe == '0)
    else $error("pins driven when deselected");
  chk_lanes_together: assert property ({dq_oe, shared_parity_oe} == '0 || {dq_oe, shared_parity_oe} == '1)
    else $error("data and parity enables differ");
  chk_wr_keeps_data: assert property (ctrl_write |=> $stable(dq_drive))
    else $error("write changed read data");
  chk_scan_fall: assert property ($changed(scan_out) |-> !scan_clk)
    else $error("scan output changed while scan clock high");
endmodule : sbs_access_port_asserts

bind sbs_access_port sbs_access_port_asserts i_sbs_access_port_asserts (.ref_clk(ref_clk), .nrst(nrst),
  .primary_chip_select_n(primary_chip_select_n), .expansion_select_high(expansion_select_high),
  .expansion_select_low(expansion_select_low), .cpu_addr_strobe_n(cpu_addr_strobe_n),
  .ctrl_addr_strobe_n(ctrl_addr_strobe_n), .byte_wr_enable_n(byte_wr_enable_n),
  .byte_lane_select_n(byte_lane_select_n), .global_wr_n(global_wr_n), .out_enable_n(out_enable_n),
  .dq_drive(dq_drive), .dq_oe(dq_oe), .shared_parity_oe(shared_parity_oe), .scan_clk(scan_clk), .scan_out(scan_out));

// file: verification/sbs_host_model.sv
// Bus owner side: resolves the shared data and parity wires.
// Assumes the bench raises host_en only with output enable held high.
`timescale 1ns/1ps

module sbs_host_model
  import sbs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        host_en,
  input  wire logic [35:0] host_word,
  input  wire logic [31:0] dq_drive,
  input  wire logic [31:0] dq_oe,
  input  wire logic [3:0]  par_drive,
  input  wire logic [3:0]  par_oe,
  output logic      [31:0] dq_sample,
  output logic      [3:0]  par_sample,
  output logic             clash
);
  logic [35:0] wire_v;
  logic [35:0] last_q = 36'h0;
  // Released wires flip each cycle so a stale value is never mistaken for data
  always_comb wire_v = host_en ? host_word : (dq_oe[0] ? {par_drive, dq_drive} : ~last_q);
  always_ff @(posedge ref_clk) last_q <= wire_v;
  assign {par_sample, dq_sample} = wire_v;
  assign clash = host_en && (dq_oe != '0 || par_oe != '0);
endmodule : sbs_host_model

// file: verification/sbs_access_port_tb_top.sv
// Self-checking bench of the access port: random and corner accesses.
// Assumes the host model on the shared wires and the bound checker.
`timescale 1ns/1ps

module sbs_access_port_tb_top
  import sbs_pkg::*;
  ;
  logic         ref_clk = 1'h0, nrst = 1'h0, mode = 1'h0, hen = 1'h0, oe_n = 1'h1;
  logic         sclk = 1'h0, sdat = 1'h0, chk_q = 1'h0, clash, sout;
  logic         smode = 1'h0, sbit = 1'h0;
  logic [17:0]  a_r = 18'h0;
  logic [35:0]  hw = 36'h0, exp_q = 36'h0;
  logic [35:0]  mem [logic [17:0]];
  logic [31:0]  dq_s, dq_d, dq_o;
  logic [3:0]   ps, pd, po;
  sbs_pins_type pv = 12'hBFF;
  int           mismatches = 0, cmp_count = 0, cyc = 0;

  initial forever #20 ref_clk = ~ref_clk;

  sbs_access_port i_sbs_access_port (.ref_clk(ref_clk), .nrst(nrst), .addr(a_r),
    .primary_chip_select_n(pv.ce1_n), .expansion_select_high(pv.ce2), .expansion_select_low(pv.ce3_n),
    .cpu_addr_strobe_n(pv.cpu_n), .ctrl_addr_strobe_n(pv.ctrl_n), .burst_advance_n(pv.adv_n),
    .byte_wr_enable_n(pv.bwe_n), .byte_lane_select_n(pv.lanes_n), .global_wr_n(pv.gw_n),
    .out_enable_n(oe_n), .burst_mode(mode), .dq_sample(dq_s), .dq_drive(dq_d), .dq_oe(dq_o),
    .shared_parity_sample(ps), .shared_parity_drive(pd), .shared_parity_oe(po), .scan_clk(sclk),
    .scan_data(sdat), .scan_mode_sel(smode), .scan_out(sout));
  sbs_host_model i_sbs_host_model (.ref_clk(ref_clk), .host_en(hen), .host_word(hw), .dq_drive(dq_d),
    .dq_oe(dq_o), .par_drive(pd), .par_oe(po), .dq_sample(dq_s), .par_sample(ps), .clash(clash));

  function automatic sbs_pins_type mk(logic cpu_n, ctrl_n, adv_n, gw_n, bwe_n, logic [3:0] ln);
    mk = '{1'h0, 1'h1, 1'h0, cpu_n, ctrl_n, adv_n, bwe_n, ln, gw_n};
  endfunction : mk
  function automatic logic [35:0] merge(logic [35:0] o, d, logic [3:0] ln);
    merge = o;
    for (int i = 0; i < 4; i++) if (!ln[i]) begin
      merge[8*i+:8] = d[8*i+:8];
      merge[32+i] = d[32+i];
    end
  endfunction : merge
  function automatic logic [1:0] blo(logic [1:0] f, k, logic m);
    blo = m ? f ^ k : f + k;
  endfunction : blo
  task automatic check(logic [35:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Result of one step shows after the next edge, so it is checked one call later
  task automatic step(sbs_pins_type v, logic [17:0] a, ea, logic [35:0] d, logic rd);
    logic w;
    w = !v.gw_n || !v.bwe_n;
    @(posedge ref_clk);
    pv <= v;
    a_r <= a;
    hw <= d;
    hen <= w;
    oe_n <= w;
    #1;
    if (chk_q) check({pd, dq_d}, exp_q);
    if (chk_q) check({po, dq_o}, {36{!oe_n}});
    check({35'h0, clash}, 36'h0);
    chk_q = rd;
    if (rd) exp_q = mem[ea];
  endtask : step
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      test_done();
    end
  end

  initial begin
    logic [17:0] a;
    logic [35:0] d;
    logic [3:0] ln;
    sbs_pins_type v;
    a = 18'($urandom(32'h802D));
    repeat (6) @(posedge ref_clk);
    nrst <= 1'h1;
    for (int n = 0; n < 24; n++) begin
      a = 18'($urandom);
      d = {4'($urandom), $urandom};
      mem[a] = d;
      step(mk(1, 0, 1, 0, 0, 4'($urandom)), a, a, d, 0);
      d = {4'($urandom), $urandom};
      ln = 4'($urandom);
      mem[a] = merge(mem[a], d, ln);
      step(mk(1, 0, 1, 1, 0, ln), a, a, d, 0);
      step(mk(0, 0, 1, 0, 0, 4'h0), a, a, ~d, 1);
    end
    $display("test random_write_read done");
    d = {4'($urandom), $urandom};
    mem[a] = d;
    step(mk(0, 1, 1, 1, 1, 4'hF), a, a, 36'h0, 0);
    step(mk(1, 1, 1, 0, 1, 4'hF), ~a, a, d, 0);
    step(mk(0, 1, 1, 1, 1, 4'hF), a, a, 36'h0, 1);
    $display("test late_write done");
    for (int m = 0; m < 2; m++) for (int f = 0; f < 4; f++) begin
      mode = m[0];
      a = {16'($urandom), 2'(f)};
      for (int k = 0; k < 4; k++) begin
        d = {4'($urandom), $urandom};
        mem[{a[17:2], 2'(k)}] = d;
        step(mk(1, 0, 1, 0, 1, 4'hF), {a[17:2], 2'(k)}, a, d, 0);
      end
      step(mk(f[0], !f[0], 1, 1, 1, 4'hF), a, a, 36'h0, 1);
      for (int k = 1; k < 6; k++)
        step(mk(1, 1, k == 5, 1, 1, 4'hF), ~a, {a[17:2], blo(a[1:0], 2'(k - (k == 5)), m[0])}, 0, 1);
    end
    $display("test bursts done");
    v = mk(0, 1, 1, 1, 1, 4'hF);
    v.ce2 = 1'h0;
    step(v, a, a, 36'h0, 0);
    step(mk(1, 1, 0, 1, 1, 4'hF), a, a, 36'h0, 0);
    check({po, dq_o}, 36'h0);
    step(mk(1, 1, 1, 1, 1, 4'hF), a, a, 36'h0, 0);
    check({po, dq_o}, 36'h0);
    $display("test deselect done");
    for (int n = 0; n < 8; n++) begin
      @(posedge ref_clk);
      if (!n[0]) begin
        sdat  <= 1'($urandom);
        smode <= 1'($urandom);
      end
      sclk <= !n[0];
      repeat (3) @(posedge ref_clk);
      #1;
      if (!n[0] && !smode) sbit = sdat;
      if (n[0]) check({35'h0, sout}, {35'h0, sbit});
    end
    $display("test scan_bypass done");
    test_done();
  end
endmodule : sbs_access_port_tb_top
